// ==== core/pcmsp_defs.vh ====
// Purpose: Shared constants of the serial sample port.
// Assumes: System clock of 100 MHz.
// Notes:   Included by every design file of the port.
`ifndef PCMSP_DEFS_VH
`define PCMSP_DEFS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PCMSP_CLK_NS        10
`define PCMSP_FRAME_NS      125000
`define PCMSP_FRAME_CYCLES  (`PCMSP_FRAME_NS / `PCMSP_CLK_NS)
`define PCMSP_MCLK_KHZ      2000
`define PCMSP_CONV_KHZ      256
`define PCMSP_SAMPLE_KHZ    8
`define PCMSP_DIV_MOD       (`PCMSP_MCLK_KHZ / `PCMSP_SAMPLE_KHZ)
`define PCMSP_DIV_STEP      (`PCMSP_CONV_KHZ / `PCMSP_SAMPLE_KHZ)

// ----------------------------------------------------------------
// Slot counting
// ----------------------------------------------------------------
`define PCMSP_CNT_SENT      5'h1F
`define PCMSP_CNT_SAT       5'h1E
`define PCMSP_B2_OFFSET     5'h0A
`define PCMSP_LAST_BIT      5'h07
`define PCMSP_WORD_END      5'h08
`define PCMSP_HOLD_FRAMES   2'h2

// ----------------------------------------------------------------
// Registers (byte addresses)
// ----------------------------------------------------------------
`define PCMSP_TXDATA_OFS    4'h0
`define PCMSP_RXDATA_OFS    4'h4
`define PCMSP_STATUS_OFS    4'h8
`define PCMSP_TXDATA_RST    8'hFF
`define PCMSP_ST_IDL        0
`define PCMSP_ST_B2         1
`define PCMSP_ST_LONG       2
`define PCMSP_ST_STANDBY    3
`define PCMSP_ST_PDOWN      4
`define PCMSP_ST_RXNEW      5
`define PCMSP_ST_DRIVE_OK   6
`define PCMSP_ST_HELD_LOW   7

`endif

// ==== core/pcmsp_slot_timer.v ====
// Purpose: Bit-clock edge detection and slot counting for one direction.
// Assumes: Inputs are synchronous to clk.
// Notes:   Count is 0 after falling edge 0; sentinel value before it.
`timescale 1ns/10ps
`include "pcmsp_defs.vh"

module pcmsp_slot_timer (
  // System
  input  wire       clk,
  input  wire       rstn,
  input  wire       ce,
  // Link pins
  input  wire       bitClock,
  input  wire       frameSync,
  input  wire       forceShort,
  // Timing
  output wire       clkRise,
  output wire       clkFall,
  output wire       syncRise,
  output reg  [4:0] slotCnt,
  output reg        longFrame
);

  reg       clkPrev;
  reg       syncPrev;
  reg [1:0] hiFalls;
  wire      syncFall;

  assign clkRise  = bitClock & ~clkPrev;
  assign clkFall  = ~bitClock & clkPrev;
  assign syncRise = frameSync & ~syncPrev;
  assign syncFall = ~frameSync & syncPrev;

  // ----------------------------------------------------------------
  // Slot counter and frame length decision
  // ----------------------------------------------------------------
  // The decision is taken from the previous pulse, so a long pulse
  // can start driving at the sync edge itself.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clkPrev   <= 1'b0;
      syncPrev  <= 1'b0;
      slotCnt   <= `PCMSP_CNT_SENT;
      hiFalls   <= 2'h0;
      longFrame <= 1'b0;
    end else if (ce) begin
      clkPrev  <= bitClock;
      syncPrev <= frameSync;
      if (syncRise) begin
        slotCnt <= (longFrame && !forceShort) ? 5'h00 : `PCMSP_CNT_SENT;
        hiFalls <= 2'h0;
      end else begin
        if (clkFall && slotCnt != `PCMSP_CNT_SAT)
          slotCnt <= slotCnt + 5'h01;
        if (clkFall && frameSync && hiFalls != 2'h3)
          hiFalls <= hiFalls + 2'h1;
      end
      if (syncFall)
        longFrame <= (hiFalls >= 2'h2);
    end
  end

endmodule // pcmsp_slot_timer

// ==== core/pcmsp_serial_port.v ====
// Purpose: Serial sample port: frame, short and time-slot modes.
// Assumes: All pins synchronous to clk; Avalon-MM register slave.
// Notes:   Samples come from and go to registers, MSB first.
//
// Functional notes
// - Bit-clock pin high two frames selects slot mode
// - Slot mode uses transmit sync, clock, data pins
// - Receive sync level picks channel B1 or B2
// - Low selects B1, high selects B2
// - B1 transmit starts first rising edge
// - B2 transmit starts eleventh rising edge
// - B1 receive starts first falling edge
// - B2 receive starts eleventh falling edge
// - Output floats whenever not sending own slot
// - Float after falling edge 8 or 18
// - Slot mode samples input on transmit falls
// - Divide master clock to 256 and 8 kHz
// - Standby when sync stays low whole frame
// - Power down while power-up pin low
// - Float two frames after any power-up
// - Long frame floats at later end
// - Short frame floats after falling edge 8
// - Frame modes sample on receive clock falls
// - Sync high two falls means long frame
`timescale 1ns/10ps
`include "pcmsp_defs.vh"

module pcmsp_serial_port #(
  parameter FRAME_CYCLES = `PCMSP_FRAME_CYCLES,
  parameter SB_W         = 14
) (
  // System
  input  wire        clk,
  input  wire        rstn,
  input  wire        ce,
  // Avalon-MM slave
  input  wire [3:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  // Link pins
  input  wire        masterClock,
  input  wire        rxBitClockModePin,
  input  wire        rxFrameSyncChanSel,
  input  wire        txBitClock,
  input  wire        txFrameSync,
  input  wire        serialSampleIn,
  input  wire        powerUpPin,
  output reg         serialSampleOut,
  output reg         serialSampleOutEn,
  // Internal converter clocks
  output reg         convClockTick,
  output reg         sampleClockTick
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [7:0]      txData;
  reg  [7:0]      rxData;
  reg             rxNew;
  reg  [7:0]      txShift;
  reg  [7:0]      rxShift;
  reg             idlMode;
  reg             chanB2;
  reg  [1:0]      highFrames;
  reg  [1:0]      lowFrames;
  reg             modePinPrev;
  reg             modePinMoved;
  reg             standby;
  reg  [SB_W-1:0] sbCnt;
  reg             bclkSeen;
  reg             mclkSeen;
  reg  [1:0]      guardFrames;
  reg             mclkPrev;
  reg  [7:0]      divAcc;
  reg  [7:0]      sampleDiv;
  wire            tRise;
  wire            tFall;
  wire            tSyncRise;
  wire [4:0]      tCnt;
  wire            tLong;
  wire            rRise;
  wire            rFall;
  wire            rSyncRise;
  wire [4:0]      rCnt;
  wire            rLong;
  wire            rxClkSel;
  wire            rxSyncSel;
  wire            powerDown;
  wire            active;
  wire            driveOk;
  wire [4:0]      stOff;
  wire [4:0]      lastShift;
  wire [4:0]      wordEnd;
  wire            txStart;
  wire            txShiftEv;
  wire            txStop;
  wire            rxCap;
  wire            rxLast;
  wire            mclkRise;
  wire [8:0]      divSum;
  wire            busRd;
  wire            busWr;
  reg  [31:0]     next_readdata;

  // Drive is allowed only from the sync edge after the second floating frame.
  localparam [1:0] GUARD_DONE = `PCMSP_HOLD_FRAMES + 2'h1;

  // ----------------------------------------------------------------
  // Mode, power and channel qualifiers
  // ----------------------------------------------------------------
  // In slot mode both directions follow the transmit clock and sync.
  assign rxClkSel  = idlMode ? txBitClock : rxBitClockModePin;
  assign rxSyncSel = idlMode ? txFrameSync : rxFrameSyncChanSel;
  assign powerDown = ~powerUpPin;
  assign active    = ~powerDown & ~standby & (lowFrames != 2'h2);
  assign driveOk   = active & (guardFrames == GUARD_DONE);
  assign stOff     = (idlMode && chanB2) ? `PCMSP_B2_OFFSET : 5'h00;
  assign lastShift = stOff + `PCMSP_LAST_BIT;
  assign wordEnd   = stOff + `PCMSP_WORD_END;
  assign mclkRise  = masterClock & ~mclkPrev;
  assign divSum    = {1'b0, divAcc} + 9'h020;

  // ----------------------------------------------------------------
  // Slot timers, one per direction
  // ----------------------------------------------------------------
  pcmsp_slot_timer u_txTimer (
    .clk        (clk),
    .rstn       (rstn),
    .ce         (ce),
    .bitClock   (txBitClock),
    .frameSync  (txFrameSync),
    .forceShort (idlMode),
    .clkRise    (tRise),
    .clkFall    (tFall),
    .syncRise   (tSyncRise),
    .slotCnt    (tCnt),
    .longFrame  (tLong)
  );

  pcmsp_slot_timer u_rxTimer (
    .clk        (clk),
    .rstn       (rstn),
    .ce         (ce),
    .bitClock   (rxClkSel),
    .frameSync  (rxSyncSel),
    .forceShort (idlMode),
    .clkRise    (rRise),
    .clkFall    (rFall),
    .syncRise   (rSyncRise),
    .slotCnt    (rCnt),
    .longFrame  (rLong)
  );

  // ----------------------------------------------------------------
  // Transmit and receive slot events
  // ----------------------------------------------------------------
  // A long frame drives from the sync edge; the others wait for the
  // rising edge that follows falling edge 0 plus the channel offset.
  assign txStart = driveOk & ((!idlMode && tLong) ? tSyncRise :
                              (tRise && tCnt == stOff));
  assign txShiftEv = serialSampleOutEn & tRise & (tCnt > stOff) &
                     (tCnt <= lastShift);
  // A long pulse outlasting the word keeps the output driven.
  assign txStop  = serialSampleOutEn & (tCnt != `PCMSP_CNT_SENT) &
                   (tCnt >= wordEnd) &
                   ((idlMode || !tLong) || !txFrameSync);
  assign rxCap   = active & rFall & (rCnt != `PCMSP_CNT_SENT) &
                   (rCnt >= stOff) & (rCnt <= lastShift);
  assign rxLast  = rxCap & (rCnt == lastShift);

  // ----------------------------------------------------------------
  // Serial output path
  // ----------------------------------------------------------------
  // The enable drops at once on power loss or standby so the shared
  // line is released even in the middle of a word.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serialSampleOut   <= 1'b0;
      serialSampleOutEn <= 1'b0;
      txShift           <= 8'h00;
    end else if (ce) begin
      if (!active) begin
        serialSampleOutEn <= 1'b0;
      end else if (txStart) begin
        serialSampleOut   <= txData[7];
        txShift           <= {txData[6:0], 1'b0};
        serialSampleOutEn <= 1'b1;
      end else if (txStop) begin
        serialSampleOutEn <= 1'b0;
      end else if (txShiftEv) begin
        serialSampleOut <= txShift[7];
        txShift         <= {txShift[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial input path
  // ----------------------------------------------------------------
  // The new word flag is set by the last bit and cleared by a read of
  // the receive register; a set in the same cycle wins.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxShift <= 8'h00;
      rxData  <= 8'h00;
      rxNew   <= 1'b0;
    end else if (ce) begin
      if (rxCap)
        rxShift <= {rxShift[6:0], serialSampleIn};
      if (rxLast) begin
        rxData <= {rxShift[6:0], serialSampleIn};
        rxNew  <= 1'b1;
      end else if (busRd && address == `PCMSP_RXDATA_OFS) begin
        rxNew <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interface mode detection
  // ----------------------------------------------------------------
  // The mode pin counts as held only if it did not move at all
  // between two sync edges, so a running bit clock never matches.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      modePinPrev  <= 1'b0;
      modePinMoved <= 1'b1;
      highFrames   <= 2'h0;
      lowFrames    <= 2'h0;
      idlMode      <= 1'b0;
      chanB2       <= 1'b0;
    end else if (ce) begin
      modePinPrev <= rxBitClockModePin;
      if (tSyncRise) begin
        modePinMoved <= 1'b0;
        if (modePinMoved || (rxBitClockModePin != modePinPrev)) begin
          highFrames <= 2'h0;
          lowFrames  <= 2'h0;
          idlMode    <= 1'b0;
        end else if (rxBitClockModePin) begin
          lowFrames <= 2'h0;
          if (highFrames != 2'h2)
            highFrames <= highFrames + 2'h1;
          idlMode <= (highFrames >= 2'h1);
        end else begin
          highFrames <= 2'h0;
          idlMode    <= 1'b0;
          if (lowFrames != 2'h2)
            lowFrames <= lowFrames + 2'h1;
        end
        chanB2 <= rxFrameSyncChanSel;
      end else if (rxBitClockModePin != modePinPrev) begin
        modePinMoved <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Standby and power-up hold-off
  // ----------------------------------------------------------------
  // Standby needs both clocks seen during the silent frame; with the
  // clocks stopped the port simply keeps its state.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      standby     <= 1'b0;
      sbCnt       <= {SB_W{1'b0}};
      bclkSeen    <= 1'b0;
      mclkSeen    <= 1'b0;
      guardFrames <= 2'h0;
    end else if (ce) begin
      if (tSyncRise) begin
        sbCnt    <= {SB_W{1'b0}};
        bclkSeen <= 1'b0;
        mclkSeen <= 1'b0;
        standby  <= 1'b0;
      end else begin
        if (sbCnt != FRAME_CYCLES[SB_W-1:0])
          sbCnt <= sbCnt + {{(SB_W-1){1'b0}}, 1'b1};
        if (tFall)
          bclkSeen <= 1'b1;
        if (mclkRise)
          mclkSeen <= 1'b1;
        if (sbCnt == FRAME_CYCLES[SB_W-1:0] && bclkSeen && mclkSeen)
          standby <= 1'b1;
      end
      // The sync edge that ends standby is the first hold-off frame.
      if (powerDown)
        guardFrames <= 2'h0;
      else if (tSyncRise && (standby || guardFrames != GUARD_DONE))
        guardFrames <= (standby ? 2'h0 : guardFrames) + 2'h1;
      else if (standby)
        guardFrames <= 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // Converter clock pre-scaler
  // ----------------------------------------------------------------
  // 256 kHz is not an integer fraction of 2000 kHz, so a phase
  // accumulator spreads 32 ticks over each 250 master clock cycles.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mclkPrev        <= 1'b0;
      divAcc          <= 8'h00;
      sampleDiv       <= 8'h00;
      convClockTick   <= 1'b0;
      sampleClockTick <= 1'b0;
    end else if (ce) begin
      mclkPrev        <= masterClock;
      convClockTick   <= 1'b0;
      sampleClockTick <= 1'b0;
      if (mclkRise && !powerDown) begin
        if (divSum >= `PCMSP_DIV_MOD) begin
          divAcc        <= divSum[7:0] - 8'hFA;
          convClockTick <= 1'b1;
        end else begin
          divAcc <= divSum[7:0];
        end
        if (sampleDiv == 8'hF9) begin
          sampleDiv       <= 8'h00;
          sampleClockTick <= 1'b1;
        end else begin
          sampleDiv <= sampleDiv + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM register slave
  // ----------------------------------------------------------------
  // Every access completes one cycle after it is seen: waitrequest
  // drops for exactly one cycle, at which edge the access is taken.
  assign busRd = read & ~waitrequest;
  assign busWr = write & ~waitrequest;

  always @* begin
    next_readdata = 32'h0000_0000;
    case (address)
      `PCMSP_TXDATA_OFS: next_readdata[7:0] = txData;
      `PCMSP_RXDATA_OFS: next_readdata[7:0] = rxData;
      `PCMSP_STATUS_OFS: begin
        next_readdata[`PCMSP_ST_IDL]      = idlMode;
        next_readdata[`PCMSP_ST_B2]       = chanB2;
        next_readdata[`PCMSP_ST_LONG]     = tLong;
        next_readdata[`PCMSP_ST_STANDBY]  = standby;
        next_readdata[`PCMSP_ST_PDOWN]    = powerDown;
        next_readdata[`PCMSP_ST_RXNEW]    = rxNew;
        next_readdata[`PCMSP_ST_DRIVE_OK] = driveOk;
        next_readdata[`PCMSP_ST_HELD_LOW] = (lowFrames == 2'h2);
      end
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
      txData      <= `PCMSP_TXDATA_RST;
    end else if (ce) begin
      if (!waitrequest) begin
        waitrequest <= 1'b1;
      end else if (read || write) begin
        waitrequest <= 1'b0;
        readdata    <= read ? next_readdata : 32'h0000_0000;
      end
      if (busWr && address == `PCMSP_TXDATA_OFS)
        txData <= writedata[7:0];
    end
  end

endmodule // pcmsp_serial_port

// ==== verification/pcmsp_port_monitor.sv ====
// Purpose: Port checker of the serial sample port.
// Assumes: One clock domain; rstn is active low.
// Notes:   Bound to the port module and sees only its ports.
`timescale 1ns/10ps

module pcmsp_port_monitor (
  // System
  input wire        clk,
  input wire        rstn,
  // Register bus
  input wire [3:0]  address,
  input wire        read,
  input wire        write,
  input wire [31:0] readdata,
  input wire        waitrequest,
  // Link and ticks
  input wire        txBitClock,
  input wire        powerUpPin,
  input wire        serialSampleOutEn,
  input wire        convClockTick,
  input wire        sampleClockTick
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  reg       bitClockPrev;
  reg [3:0] fallCnt;
  reg [5:0] convCnt;
  reg       tickSeen;

  // Pin falls during a drive burst, converter ticks per sample period.
  // The first period after reset or power down is partial, so it is not judged.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bitClockPrev <= 1'b0;
      fallCnt      <= 4'h0;
      convCnt      <= 6'h00;
      tickSeen     <= 1'b0;
    end else begin
      bitClockPrev <= txBitClock;
      fallCnt      <= serialSampleOutEn ? fallCnt + {3'h0, bitClockPrev & ~txBitClock} : 4'h0;
      convCnt      <= sampleClockTick ? 6'h00 : convCnt + {5'h00, convClockTick};
      tickSeen     <= powerUpPin & (tickSeen | sampleClockTick);
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking mcb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_ACK_NEXT: assert property ((read | write) & waitrequest |=> !waitrequest)
    else $error("access not answered after one cycle");
  AST_ACK_ONE: assert property (!waitrequest |=> waitrequest)
    else $error("wait release longer than one cycle");
  AST_ACK_CAUSE: assert property ($fell(waitrequest) |-> $past(read | write))
    else $error("answer without request");
  AST_UNMAPPED: assert property (read & !waitrequest & (address != 4'h0) & (address != 4'h4)
    & (address != 4'h8) |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_UPPER_ZERO: assert property (read & !waitrequest |-> readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_PD_FLOAT: assert property ((!powerUpPin) [*4] |-> !serialSampleOutEn)
    else $error("output driven in power down");
  AST_BURST_MAX: assert property (serialSampleOutEn |-> fallCnt <= 4'h8)
    else $error("output driven past eighth fall");
  AST_BURST_END: assert property ($fell(serialSampleOutEn) & powerUpPin |-> fallCnt == 4'h8)
    else $error("output released before eighth fall");
  AST_TICK_PULSE: assert property (sampleClockTick |=> !sampleClockTick)
    else $error("sample tick longer than one cycle");
  AST_CONV_COUNT: assert property (sampleClockTick & tickSeen |->
    ({1'b0, convCnt} + {6'h00, convClockTick}) == 7'h20)
    else $error("converter ticks per sample period wrong");

  cover property (read & !waitrequest);
  cover property (write & !waitrequest);
  cover property ($fell(serialSampleOutEn));
endmodule // pcmsp_port_monitor

bind pcmsp_serial_port pcmsp_port_monitor i_pcmsp_port_monitor (
  .clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .txBitClock(txBitClock),
  .powerUpPin(powerUpPin), .serialSampleOutEn(serialSampleOutEn),
  .convClockTick(convClockTick), .sampleClockTick(sampleClockTick));

// ==== verification/pcmsp_link_partner.sv ====
// Purpose: Far-side link controller: bit clock, frame sync, sample exchange.
// Assumes: Bit period of 2*HALF system clocks, NBITS periods per frame.
// Notes:   Reports per frame what the device sent in its slot.
`timescale 1ns/10ps

module pcmsp_link_partner #(
  parameter HALF  = 5,
  parameter NBITS = 24
) (
  // System
  input wire       clk,
  // Bench control
  input wire       syncOn,
  input wire       longSync,
  input wire       chanB2,
  input wire [7:0] sendByte,
  // Device pins
  input wire       serialSampleOut,
  input wire       serialSampleOutEn,
  output reg       bitClock,
  output reg       frameSync,
  output reg       sampleIn,
  // Frame report
  output reg       frameDone,
  output reg [7:0] gotByte,
  output reg       drove,
  output reg       stray
);
  integer   n;
  integer   s;
  reg [7:0] acc;
  reg       allOn;
  reg       anyOn;
  reg       frOn;
  reg       frLong;
  reg       frB2;

  // Free-running bit clock, which also feeds the master clock input.
  // Outside the slot the data line toggles, so a stale bit never passes.
  initial begin
    bitClock  = 1'b0;
    frameSync = 1'b0;
    sampleIn  = 1'b0;
    frameDone = 1'b0;
    gotByte   = 8'h00;
    drove     = 1'b0;
    stray     = 1'b0;
    forever begin
      acc   = 8'h00;
      allOn = 1'b1;
      anyOn = 1'b0;
      for (n = 0; n < NBITS; n = n + 1) begin
        @(posedge clk);
        // Settings are taken once per frame so a change never splits a pulse.
        if (n == 0) begin
          frOn   = syncOn;
          frLong = longSync;
          frB2   = chanB2;
        end
        s = n - (frB2 ? 10 : 0);
        bitClock  <= 1'b1;
        frameDone <= 1'b0;
        frameSync <= frOn & (frLong ? (n == 1 || n == 2) : (n == 0));
        sampleIn  <= (s >= 1 && s <= 8) ? sendByte[8 - s] : ~sampleIn;
        repeat (HALF) @(posedge clk);
        bitClock <= 1'b0;
        if (s >= 1 && s <= 8) begin
          acc[8 - s] = serialSampleOut;
          allOn = allOn & (serialSampleOutEn === 1'b1);
        end else if (serialSampleOutEn !== 1'b0) begin
          anyOn = 1'b1;
        end
        repeat (HALF - 1) @(posedge clk);
      end
      gotByte   <= acc;
      drove     <= allOn;
      stray     <= anyOn;
      frameDone <= 1'b1;
    end
  end
endmodule // pcmsp_link_partner

// ==== verification/tb_top.sv ====
// Purpose: Self-checking bench of the serial sample port.
// Assumes: Shortened frame timeout; bit clock of ten system clocks.
// Notes:   Expected bytes and drive windows come from the bench model.
`timescale 1ns/10ps

module tb_top;
  reg         clk, rstn, read, write, powerUpPin;
  reg         idl, syncOn, longSync, chanB2;
  reg  [3:0]  address;
  reg  [31:0] writedata;
  reg  [7:0]  sendByte, txByte;
  wire [31:0] readdata;
  wire        waitrequest, txBitClock, txFrameSync, serialSampleIn;
  wire        serialSampleOut, serialSampleOutEn, frameDone, drove, stray;
  wire [7:0]  gotByte;
  integer     seed, fail_count, check_count;
  // In slot mode the receive pins become static straps.
  wire        rxBitClockModePin  = idl ? 1'b1 : txBitClock;
  wire        rxFrameSyncChanSel = idl ? chanB2 : txFrameSync;

  pcmsp_serial_port #(.FRAME_CYCLES(300), .SB_W(14)) i_pcmsp_serial_port (
    .clk(clk), .rstn(rstn), .ce(1'b1), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .masterClock(txBitClock), .rxBitClockModePin(rxBitClockModePin),
    .rxFrameSyncChanSel(rxFrameSyncChanSel), .txBitClock(txBitClock),
    .txFrameSync(txFrameSync), .serialSampleIn(serialSampleIn), .powerUpPin(powerUpPin),
    .serialSampleOut(serialSampleOut), .serialSampleOutEn(serialSampleOutEn),
    .convClockTick(), .sampleClockTick());

  pcmsp_link_partner i_pcmsp_link_partner (
    .clk(clk), .syncOn(syncOn), .longSync(longSync), .chanB2(chanB2),
    .sendByte(sendByte), .serialSampleOut(serialSampleOut),
    .serialSampleOutEn(serialSampleOutEn), .bitClock(txBitClock), .frameSync(txFrameSync),
    .sampleIn(serialSampleIn), .frameDone(frameDone), .gotByte(gotByte), .drove(drove),
    .stray(stray));

  // 100 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task check(input logic [31:0] seen, input logic [31:0] want);
    begin
      check_count = check_count + 1;
      if (seen !== want) begin
        fail_count = fail_count + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
      end
    end
  endtask

  // One bus access; the request stands until waitrequest is sampled low.
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    integer t;
    begin
      t = 0;
      address <= a;
      writedata <= d;
      read <= ~wr;
      write <= wr;
      @(posedge clk);
      while (waitrequest !== 1'b0 && t < 50) begin
        @(posedge clk);
        t = t + 1;
      end
      if (t == 50) fail_count = fail_count + 1;
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
    end
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task rd(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] want);
    logic [31:0] q;
    begin
      bus(1'b0, a, 32'h0, q);
      check(q & mask, want);
    end
  endtask

  // New random sample for each direction.
  task newdata;
    begin
      txByte = 8'($random(seed));
      sendByte <= 8'($random(seed));
      wr(4'h0, {24'h0, txByte});
    end
  endtask

  // Waits one frame; want is 0 float, 1 drive and receive, 2 not judged.
  task frame(input integer want);
    integer t;
    begin
      t = 0;
      @(posedge clk);
      while (frameDone !== 1'b1 && t < 400) begin
        @(posedge clk);
        t = t + 1;
      end
      if (t == 400) fail_count = fail_count + 1;
      if (want != 2) begin
        check(drove, want[0]);
        check(stray, 32'h0);
      end
      if (want == 1) begin
        check(gotByte, txByte);
        rd(4'h8, 32'h20, 32'h20);
        rd(4'h4, 32'hFF, sendByte);
      end
    end
  endtask

  task skip(input integer k);
    repeat (k) frame(2);
  endtask

  // Two floating frames after any power state, then driving again.
  task hold;
    begin
      frame(0);
      frame(0);
      frame(2);
      frame(1);
    end
  endtask

  task complete_run;
    begin
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // Watchdog well beyond the thirty-two frames of the sequence.
  initial begin
    #400000;
    fail_count = fail_count + 1;
    complete_run;
  end

  initial begin
    seed = 14;
    fail_count = 0;
    check_count = 0;
    {rstn, read, write, idl, syncOn, longSync, chanB2} = 7'h00;
    powerUpPin = 1'b1;
    address = 4'h0;
    writedata = 32'h0;
    sendByte = 8'h00;
    txByte = 8'hFF;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(4'h0, 32'hFFFFFFFF, 32'hFF);
    wr(4'hC, 32'h5A);
    rd(4'hC, 32'hFFFFFFFF, 32'h0);
    syncOn <= 1'b1;
    newdata;
    skip(1);
    hold;
    rd(4'h8, 32'h1D, 32'h0);
    longSync <= 1'b1;
    newdata;
    skip(2);
    frame(1);
    rd(4'h8, 32'h04, 32'h04);
    longSync <= 1'b0;
    idl <= 1'b1;
    newdata;
    skip(3);
    frame(1);
    rd(4'h8, 32'h03, 32'h01);
    chanB2 <= 1'b1;
    newdata;
    skip(2);
    frame(1);
    rd(4'h8, 32'h03, 32'h03);
    skip(1);
    idl <= 1'b0;
    chanB2 <= 1'b0;
    skip(2);
    frame(1);
    rd(4'h8, 32'h01, 32'h00);
    powerUpPin <= 1'b0;
    skip(1);
    frame(0);
    rd(4'h8, 32'h10, 32'h10);
    powerUpPin <= 1'b1;
    hold;
    syncOn <= 1'b0;
    skip(1);
    frame(0);
    frame(0);
    rd(4'h8, 32'h08, 32'h08);
    syncOn <= 1'b1;
    hold;
    complete_run;
  end
endmodule // tb_top
